//--- logic/source_transfer_controller.v
// source transfer controller: picks which of two sources feeds the load
// assumes synchronous inputs, one pclk, APB register access from the touchscreen
//
// What this block does
// - normal mode: load on healthy preferred source
// - preferred fails: move load to alternate
// - no return: stay on alternate while healthy
// - auto return after delay, 4 s to 10 min
// - manual transfer needs healthy, in-phase target
// - phase window resets 20 deg, max 180
// - override permits manual transfer up to 180
// - high load current blocks all transfers
// - current block clears when current falls
// - shorted active element: alarm, trip other breaker
// - shorted idle plus cross-current: move, alarm, trip
// - open element: alarm; open active element: move to other
// - element alarms latch until explicit reset
// - self power up; normal, bypass, redundant modes
// - redundant mode: auto transfer on bad source
// - redundant mode: selector switch picks source
// - bypass guide advances on sensed step completion
// - count transfers since counter reset
// - only touchscreen may write controls
// - operator sets preferred source, requests transfers
// - break-before-make, never both conducting
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`include "xfer_ctrl_regs.vh"

module source_transfer_controller #(
   parameter DELAY_SEC_CYCLES = `SEC_CYCLES,
   parameter GAP_CYCLES       = 4,
   parameter BYPASS_STEPS     = 6
) (
   // apb
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output wire        pslverr,
   output reg  [31:0] prdata,
   // origin of write: high only for the local touchscreen
   input  wire        local_panel_src,
   // source measurements
   input  wire        src1_ok,
   input  wire        src2_ok,
   input  wire [7:0]  phase_diff_deg,
   input  wire        over_current,
   // switch element sense (index 0 = source 1)
   input  wire [1:0]  element_shorted,
   input  wire [1:0]  element_open,
   input  wire        cross_current,
   // backup operator panel
   input  wire        backup_mode_redundant,
   input  wire        source_choice_switch,
   // bypass procedure
   input  wire        bypass_step_done,
   // outputs
   output reg         gate_src1,
   output reg         gate_src2,
   output reg         trip_breaker1,
   output reg         trip_breaker2,
   output reg         alarm,
   output reg  [3:0]  bypass_step
);

   // ==========================================
   // states
   localparam ST_ON1   = 2'h0;
   localparam ST_ON2   = 2'h1;
   localparam ST_GAP   = 2'h2;

   reg  [1:0]  state_reg;
   reg         target_reg;       // source being connected after gap
   reg  [3:0]  gap_cnt_reg;
   reg         pref_reg;
   reg         return_reg;
   reg  [1:0]  mode_reg;
   reg  [15:0] ret_sec_reg;
   reg  [7:0]  win_reg;
   reg  [31:0] tick_reg;
   reg  [15:0] sec_reg;
   reg  [31:0] count_reg;
   reg  [3:0]  alarm_bits_reg;   // short2 short1 open2 open1
   reg         cmd_xfer_reg;
   reg         cmd_ovr_reg;
   reg         prev_choice_reg;

   // health of source 2 when sel is high, else of source 1
   function src_pick;
      input sel;
      input ok1;
      input ok2;
      begin
         src_pick = sel ? ok2 : ok1;
      end
   endfunction

   wire on_src     = (state_reg == ST_ON2);
   wire src_ok_on  = src_pick(on_src, src1_ok, src2_ok);
   wire src_ok_oth = src_pick(~on_src, src1_ok, src2_ok);
   wire pref_ok    = src_pick(pref_reg, src1_ok, src2_ok);
   wire on_pref    = (on_src == pref_reg);
   wire latched    = |alarm_bits_reg;

   // ==========================================
   // apb: zero wait states
   wire wr_en  = psel & penable & pwrite;
   wire wr_ok  = wr_en & local_panel_src;
   wire cmd_wr = wr_ok & (paddr == `OFF_CMD);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & pwrite & ~local_panel_src;

   function [7:0] clamp_win;
      input [7:0] v;
      begin
         clamp_win = (v > `PHASE_WIN_MAX) ? `PHASE_WIN_MAX : v;
      end
   endfunction

   function [15:0] clamp_delay;
      input [15:0] v;
      begin
         if (v < `RET_DELAY_MIN_S)
            clamp_delay = `RET_DELAY_MIN_S;
         else if (v > `RET_DELAY_MAX_S)
            clamp_delay = `RET_DELAY_MAX_S;
         else
            clamp_delay = v;
      end
   endfunction

   // read word for an address; taken in the setup cycle so prdata comes
   // from flip-flops and still stands through the zero-wait access
   function [31:0] rd_word;
      input [11:0] a;
      begin
         case (a)
            `OFF_CTRL:      rd_word = {28'h0, mode_reg, return_reg, pref_reg};
            `OFF_RET_DELAY: rd_word = {16'h0, ret_sec_reg};
            `OFF_PHASE_WIN: rd_word = {24'h0, win_reg};
            `OFF_STATUS:    rd_word = {22'h0, bypass_step, over_current, latched,
                                       gate_src2, gate_src1, state_reg};
            `OFF_ALARM:     rd_word = {28'h0, alarm_bits_reg};
            `OFF_COUNT:     rd_word = count_reg;
            default:        rd_word = 32'h0000_0000;
         endcase
      end
   endfunction

   wire rd_setup = psel & ~penable & ~pwrite;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= rd_word(paddr);
      end else if (~psel) begin
         prdata <= 32'h0000_0000;
      end
   end

   // ==========================================
   // decision logic
   reg  want_move;
   reg  delay_run;
   wire in_window = (phase_diff_deg <= win_reg);
   wire choice_edge = source_choice_switch ^ prev_choice_reg;

   // reasons to move, each on its own
   wire fail_move   = ~src_ok_on & src_ok_oth;
   wire return_wait = ~on_pref & pref_ok & return_reg & ~latched;
   wire manual_move = cmd_xfer_reg & src_ok_oth & (in_window | cmd_ovr_reg);
   wire choice_move = choice_edge & (source_choice_switch != on_src) & src_ok_oth;
   wire open_move   = element_open[on_src];
   wire short_move  = element_shorted[~on_src] & cross_current;

   always @* begin
      want_move = 1'b0;
      delay_run = 1'b0;
      case (mode_reg)
         `MODE_NORMAL: begin
            if (fail_move)
               want_move = 1'b1;
            else if (return_wait) begin
               delay_run = 1'b1;
               want_move = (sec_reg >= ret_sec_reg);
            end
            if (manual_move)
               want_move = 1'b1;
         end
         `MODE_REDUNDANT: begin
            if (fail_move)
               want_move = 1'b1;
            if (choice_move)
               want_move = 1'b1;
         end
         default: want_move = 1'b0;  // bypass: electronics isolated
      endcase
      if (open_move)
         want_move = 1'b1;
      if (short_move)
         want_move = 1'b1;
      if (over_current)
         want_move = 1'b0;
   end

   // element alarms latch; a fault present in the clear cycle wins over it
   reg  [3:0] alarm_bits_next;

   always @* begin
      alarm_bits_next = alarm_bits_reg | {element_shorted, element_open};
      if (cmd_wr & pwdata[`CMD_ALARM_RST])
         alarm_bits_next = {element_shorted, element_open};
   end

   // ==========================================
   // registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg       <= ST_ON1;
         target_reg      <= 1'b0;
         gap_cnt_reg     <= 4'h0;
         pref_reg        <= 1'b0;
         return_reg      <= 1'b0;
         mode_reg        <= `MODE_NORMAL;
         ret_sec_reg     <= `RET_DELAY_MIN_S;
         win_reg         <= `PHASE_WIN_RST;
         count_reg       <= 32'h0;
         alarm_bits_reg  <= 4'h0;
         cmd_xfer_reg    <= 1'b0;
         cmd_ovr_reg     <= 1'b0;
         prev_choice_reg <= 1'b0;
         gate_src1       <= 1'b0;
         gate_src2       <= 1'b0;
         alarm           <= 1'b0;
      end else begin
         prev_choice_reg <= source_choice_switch;
         cmd_xfer_reg    <= 1'b0;
         cmd_ovr_reg     <= 1'b0;
         if (wr_ok) begin
            case (paddr)
               `OFF_CTRL: begin
                  pref_reg   <= pwdata[`CTRL_PREF_BIT];
                  return_reg <= pwdata[`CTRL_RETURN_BIT];
                  if (pwdata[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB] != 2'h3)
                     mode_reg <= pwdata[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
               end
               `OFF_RET_DELAY: ret_sec_reg <= clamp_delay(pwdata[15:0]);
               `OFF_PHASE_WIN: win_reg <= clamp_win(pwdata[7:0]);
               `OFF_CMD: begin
                  cmd_xfer_reg <= pwdata[`CMD_XFER_BIT];
                  cmd_ovr_reg  <= pwdata[`CMD_OVERRIDE_BIT];
               end
               default: ;
            endcase
         end
         if (backup_mode_redundant)
            mode_reg <= `MODE_REDUNDANT;

         alarm_bits_reg <= alarm_bits_next;
         alarm          <= |alarm_bits_next;

         // transfer sequencer: off gap between sources
         case (state_reg)
            ST_ON1, ST_ON2: begin
               gate_src1 <= (state_reg == ST_ON1) & (mode_reg != `MODE_BYPASS);
               gate_src2 <= (state_reg == ST_ON2) & (mode_reg != `MODE_BYPASS);
               if (want_move) begin
                  gate_src1   <= 1'b0;
                  gate_src2   <= 1'b0;
                  target_reg  <= ~on_src;
                  gap_cnt_reg <= 4'h0;
                  state_reg   <= ST_GAP;
               end
            end
            ST_GAP: begin
               gate_src1 <= 1'b0;
               gate_src2 <= 1'b0;
               if (gap_cnt_reg >= GAP_CYCLES - 1) begin
                  state_reg <= target_reg ? ST_ON2 : ST_ON1;
                  count_reg <= count_reg + 32'h1;
               end else begin
                  gap_cnt_reg <= gap_cnt_reg + 4'h1;
               end
            end
            default: state_reg <= ST_ON1;
         endcase
         if (cmd_wr & pwdata[`CMD_COUNT_RST])
            count_reg <= 32'h0;
      end
   end

   // ==========================================
   // return delay seconds, restarted whenever preferred drops
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_reg <= 32'h0;
         sec_reg  <= 16'h0;
      end else begin
         if (!delay_run) begin
            tick_reg <= 32'h0;
            sec_reg  <= 16'h0;
         end else if (tick_reg >= DELAY_SEC_CYCLES - 1) begin
            tick_reg <= 32'h0;
            if (sec_reg != 16'hffff)
               sec_reg <= sec_reg + 16'h1;
         end else begin
            tick_reg <= tick_reg + 32'h1;
         end
      end
   end

   // ==========================================
   // breaker trips stay until alarm reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trip_breaker1 <= 1'b0;
         trip_breaker2 <= 1'b0;
      end else begin
         if (element_shorted[0] & (~on_src | cross_current))
            trip_breaker2 <= 1'b1;
         else if (~latched)
            trip_breaker2 <= 1'b0;
         if (element_shorted[1] & (on_src | cross_current))
            trip_breaker1 <= 1'b1;
         else if (~latched)
            trip_breaker1 <= 1'b0;
      end
   end

   // ==========================================
   // bypass guide
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bypass_step <= 4'h0;
      end else begin
         if (mode_reg != `MODE_BYPASS)
            bypass_step <= 4'h0;
         else if (bypass_step_done && bypass_step < BYPASS_STEPS - 1)
            bypass_step <= bypass_step + 4'h1;
      end
   end

   // ==========================================
   // notes for the next engineer
   // - gate outputs are conduction commands; the gap state always
   //   sits between two of them, so no decision can make both high
   // - want_move is looked at only in ST_ON1 and ST_ON2; a manual
   //   command or selector edge landing in the gap is dropped,
   //   the operator simply repeats it
   // - over-current inhibit also blocks fault moves; traded for never
   //   switching a heavy load into a fault
   // - return timer counts whole seconds of DELAY_SEC_CYCLES; any dip
   //   of the preferred source zeroes it, so a flickering source
   //   never earns its way back
   // - return is held off while any element alarm is latched
   // - an alarm clear with the fault still sensed leaves it latched
   // - trips drop one cycle after the latch clears, never earlier
   // - the panel redundant switch forces the mode each cycle; the
   //   mode stays redundant after release until software rewrites it
   // - mode code 3 is ignored, the old mode stays
   // - remote writes get pslverr and change nothing
   // - prdata is taken in the setup cycle; a status read shows the
   //   state one cycle before the access edge
   // - bypass step saturates at BYPASS_STEPS - 1 and clears on exit
   // - element sense inputs are levels; a one-cycle glitch still
   //   latches an alarm, by intent

endmodule

//--- logic/xfer_ctrl_regs.vh
// register map, field positions and timing constants for the transfer controller
// assumes a 10 MHz pclk and an APB slave with 32-bit data
`ifndef XFER_CTRL_REGS_VH
`define XFER_CTRL_REGS_VH

// ==========================================
// offsets (byte addresses)
`define OFF_CTRL      12'h000
`define OFF_RET_DELAY 12'h004
`define OFF_PHASE_WIN 12'h008
`define OFF_CMD       12'h00c
`define OFF_STATUS    12'h010
`define OFF_ALARM     12'h014
`define OFF_COUNT     12'h018

// ==========================================
// control register fields
`define CTRL_PREF_BIT   0
`define CTRL_RETURN_BIT 1
`define CTRL_MODE_LSB   2
// command register fields (write-only pulses)
`define CMD_XFER_BIT     0
`define CMD_OVERRIDE_BIT 1
`define CMD_ALARM_RST    2
`define CMD_COUNT_RST    3

// ==========================================
// modes
`define MODE_NORMAL    2'h0
`define MODE_BYPASS    2'h1
`define MODE_REDUNDANT 2'h2

// ==========================================
// reset values and limits
`define PHASE_WIN_RST   8'h14
`define PHASE_WIN_MAX   8'hb4
`define RET_DELAY_MIN_S 16'h0004
`define RET_DELAY_MAX_S 16'h0258
`define CLK_HZ          10000000
`define SEC_CYCLES      (`CLK_HZ)

`endif

//--- tb/stc_assertions.sv
// port checker for the source transfer controller
// assumes one pclk domain; attached by the bind at the foot
`include "xfer_ctrl_regs.vh"
module stc_checker (
   // apb side
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire        pslverr,
   input wire        local_panel_src,
   // field inputs
   input wire        over_current,
   input wire        bypass_step_done,
   // outputs
   input wire        gate_src1,
   input wire        gate_src2,
   input wire        trip_breaker1,
   input wire        trip_breaker2,
   input wire        alarm,
   input wire [3:0]  bypass_step
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr_acc = psel && penable && pwrite;
   wire clr = wr_acc && local_panel_src && paddr == `OFF_CMD && pwdata[`CMD_ALARM_RST];
   a_never_both: assert property (!(gate_src1 && gate_src2))
      else $error("both sources gated");
   a_gap_from1: assert property ($fell(gate_src1) |-> !gate_src2 [*4])
      else $error("no dead gap after source 1");
   a_gap_from2: assert property ($fell(gate_src2) |-> !gate_src1 [*4])
      else $error("no dead gap after source 2");
   a_remote_refused: assert property (wr_acc |-> pslverr == !local_panel_src)
      else $error("write origin not judged");
   a_current_blocks: assert property (over_current [*2] |->
      !$fell(gate_src1) && !$fell(gate_src2))
      else $error("transfer under over current");
   a_alarm_latched: assert property (alarm && !clr |=> alarm)
      else $error("alarm dropped without reset");
   a_trip1_alarm: assert property ($rose(trip_breaker1) |-> alarm)
      else $error("breaker 1 trip without alarm");
   a_trip2_alarm: assert property ($rose(trip_breaker2) |-> alarm)
      else $error("breaker 2 trip without alarm");
   a_step_cause: assert property (bypass_step != $past(bypass_step) && bypass_step != 4'h0
      |-> $past(bypass_step_done) && bypass_step == $past(bypass_step) + 4'h1)
      else $error("bypass step moved on its own");
endmodule

bind source_transfer_controller stc_checker stc_checker_i (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pslverr, .local_panel_src, .over_current, .bypass_step_done,
   .gate_src1, .gate_src2, .trip_breaker1, .trip_breaker2, .alarm, .bypass_step);

//--- tb/source_model.sv
// two ac sources behind their input breakers
// assumes the bench sets source faults at pclk edges
module source_model (
   // bench-commanded source failures
   input  wire fail1,
   input  wire fail2,
   // breaker trips from the controller
   input  wire trip_breaker1,
   input  wire trip_breaker2,
   // measured health
   output wire src1_ok,
   output wire src2_ok
);
   timeunit 1ns;
   timeprecision 1ns;
   // an open breaker takes its source off the sense lines too
   assign src1_ok = !fail1 && !trip_breaker1;
   assign src2_ok = !fail2 && !trip_breaker2;
endmodule

//--- tb/tb_top.sv
// self-checking bench for the source transfer controller
// assumes the register header on the include path
`include "xfer_ctrl_regs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
   logic        lps = 1, f1 = 0, f2 = 0, oc = 0, xc = 0, red = 0, sel = 0, sd = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, r;
   logic [7:0]  ph = '0;
   logic [1:0]  sh = '0, op = '0, a;
   wire  [31:0] prdata;
   wire         pready, pslverr, s1, s2, g1, g2, t1, t2, alarm;
   wire  [3:0]  step;
   int          fails = 0, n_checks = 0, n;
   always #50 pclk = ~pclk;
   source_model source_model_i (.fail1(f1), .fail2(f2), .trip_breaker1(t1),
      .trip_breaker2(t2), .src1_ok(s1), .src2_ok(s2));
   // one second shortened to 10 cycles
   source_transfer_controller #(.DELAY_SEC_CYCLES(10)) source_transfer_controller_i (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
      .prdata, .local_panel_src(lps), .src1_ok(s1), .src2_ok(s2), .phase_diff_deg(ph),
      .over_current(oc), .element_shorted(sh), .element_open(op), .cross_current(xc),
      .backup_mode_redundant(red), .source_choice_switch(sel), .bypass_step_done(sd),
      .gate_src1(g1), .gate_src2(g2), .trip_breaker1(t1), .trip_breaker2(t2), .alarm,
      .bypass_step(step));
   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task bus(input w, input [11:0] ad, input [31:0] d);
      int i;
      i = 0;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, d};
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++i < 20);
      if (pready !== 1'b1) begin fails++; stop_test; end
      {r, e} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask
   // wait for a gate pattern, c counts cycles spent
   task wt(input [1:0] g, output int c);
      n_checks++;
      for (c = 0; c < 300 && {g2, g1} !== g; c++) @(negedge pclk);
      if (c == 300) begin fails++; stop_test; end
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      wt(2'b01, n);
      bus(0, `OFF_PHASE_WIN, '0);
      chk(r, 32'h14);
      bus(1, `OFF_RET_DELAY, 32'h1);
      bus(0, `OFF_RET_DELAY, '0);
      chk(r, 32'h4);
      @(posedge pclk) lps <= 1'b0;
      bus(1, `OFF_CTRL, 32'h1);
      chk({31'h0, e}, 32'h1);
      @(posedge pclk) lps <= 1'b1;
      $display("test registers done");
      @(posedge pclk) f1 <= 1'b1;
      wt(2'b10, n);
      bus(0, `OFF_COUNT, '0);
      chk(r, 32'h1);
      @(posedge pclk) f1 <= 1'b0;
      repeat (40) @(negedge pclk);
      chk({g2, g1}, 2'b10);
      @(posedge pclk) f2 <= 1'b1;
      wt(2'b01, n);
      @(posedge pclk) {f2, ph} <= {1'b0, 8'h1e};
      bus(1, `OFF_CMD, 32'h1);
      repeat (10) @(negedge pclk);
      chk({g2, g1}, 2'b01);
      @(posedge pclk) ph <= 8'hb4;
      bus(1, `OFF_CMD, 32'h3);
      wt(2'b10, n);
      bus(1, `OFF_PHASE_WIN, 32'hc8);
      bus(0, `OFF_PHASE_WIN, '0);
      chk(r, 32'hb4);
      $display("test manual done");
      bus(1, `OFF_CTRL, 32'h2);
      wt(2'b01, n);
      @(posedge pclk) f1 <= 1'b1;
      wt(2'b10, n);
      @(posedge pclk) f1 <= 1'b0;
      repeat (20) @(posedge pclk);
      f1 <= 1'b1;
      @(posedge pclk) f1 <= 1'b0;
      wt(2'b01, n);
      chk(32'(n >= 40), 32'h1);
      @(posedge pclk) {oc, f1} <= 2'b11;
      repeat (20) @(negedge pclk);
      chk({g2, g1}, 2'b01);
      @(posedge pclk) oc <= 1'b0;
      wt(2'b10, n);
      @(posedge pclk) f1 <= 1'b0;
      bus(1, `OFF_CTRL, 32'h0);
      $display("test return and current done");
      a = {g2, g1};
      @(posedge pclk) op <= a;
      wt({a[0], a[1]}, n);
      @(posedge pclk) op <= 2'b00;
      repeat (5) @(negedge pclk);
      chk(alarm, 1'b1);
      bus(0, `OFF_ALARM, '0);
      chk(r, 32'h2);
      bus(1, `OFF_CMD, 32'h4);
      @(negedge pclk) chk(alarm, 1'b0);
      a = {g2, g1};
      @(posedge pclk) sh <= a;
      repeat (3) @(negedge pclk);
      chk({alarm, t2, t1}, {1'b1, a[0], a[1]});
      @(posedge pclk) sh <= 2'b00;
      bus(1, `OFF_CMD, 32'h4);
      @(posedge pclk) {sh, xc} <= 3'b101;
      wt(2'b10, n);
      chk({alarm, t1}, 2'b11);
      @(posedge pclk) {sh, xc} <= 3'b000;
      bus(1, `OFF_CMD, 32'h4);
      $display("test element faults done");
      @(posedge pclk) {red, sel} <= 2'b11;
      repeat (10) @(negedge pclk);
      chk({g2, g1}, 2'b10);
      @(posedge pclk) sel <= 1'b0;
      wt(2'b01, n);
      @(posedge pclk) sel <= 1'b1;
      wt(2'b10, n);
      @(posedge pclk) f2 <= 1'b1;
      wt(2'b01, n);
      @(posedge pclk) {f2, red} <= 2'b00;
      bus(1, `OFF_CTRL, 32'h4);
      repeat (2) begin
         @(posedge pclk) sd <= 1'b1;
         @(posedge pclk) sd <= 1'b0;
      end
      repeat (3) @(negedge pclk);
      chk(step, 4'h2);
      $display("test redundant and bypass done");
      bus(1, `OFF_CMD, 32'h8);
      bus(0, `OFF_COUNT, '0);
      chk(r, 32'h0);
      stop_test;
   end
endmodule
